/* File: logic/mcu_seq.sv */
// Register access over Wishbone and the register addresses were left to the implementer.
`timescale 1ns/1ps
// How it works
// - Program space is two chapters of 16 pages, 64 words each.
// - Three one-bit chapter controls: current, buffer, subroutine return.
// - Chapter buffer flip inverts buffer only, other chapter bits untouched.
// - Taken jump or call copies buffer into current chapter.
// - Taken call saves the chapter being left into return bit.
// - Buffer changes inside a subroutine never touch the saved return bit.
// - Jump and call act only on status one; zero lasts one instruction.
// - Increments (except the Y increment of constant store) and additions set status from carry out of bit 3.
// - Subtract gives memory minus acc; decrements set status on no borrow.
// - Add-constant adds a 4-bit constant 0..15 into the accumulator, 4-bit result.
// - Negate forms two's complement of acc; status one if zero.
// - Not-equal tests set status on inequality; Y-vs-acc also loads latch.
// - Acc less-or-equal memory sets status one.
// - Bit set, clear and test on the addressed memory word.
// - Key test sets status if keys nonzero; key load copies keys.
// - Strobe latch by Y set or cleared; parallel out takes acc+latch.
// - File pointer loads from constant; flip inverts its top bit only.
// - Memory is eight files of 16 four-bit words, X then Y.
// - Large package gives 16 strobe latches and eight parallel outputs.
// - Moves between acc, Y and memory, including clear and exchange.
// - Constant to Y, constant store with Y increment, page buffer load.
module mcu_seq #(
    parameter int N_STROBE = mcu_seq_pkg::N_STROBE,
    parameter int PAR_W    = mcu_seq_pkg::PAR_W
) (
    input  wire logic                i_sys_clk,  // System clock
    input  wire logic                i_nrst,     // Async reset, active low
    input  wire logic                i_wb_cyc,   // Bus cycle
    input  wire logic                i_wb_stb,   // Bus strobe
    input  wire logic                i_wb_we,    // Write enable
    input  wire logic [7:0]          i_wb_adr,   // Byte address
    input  wire logic [3:0]          i_wb_sel,   // Byte selects
    input  wire logic [31:0]         i_wb_dat,   // Write data
    output logic      [31:0]         o_wb_dat,   // Read data
    output logic                     o_wb_ack,   // Acknowledge
    input  wire logic [3:0]          i_keys,     // Sense inputs
    output logic      [N_STROBE-1:0] o_strobe,   // Strobe latches
    output logic      [PAR_W-1:0]    o_par       // Parallel outputs
);
    // ----------------------------------------------------------------
    // Bus slave
    // ----------------------------------------------------------------
    mcu_seq_pkg::instr_t  ins;
    logic                 req;
    logic                 exec;
    logic [31:0]          nxt_rdat;

    assign req  = i_wb_cyc && i_wb_stb && !o_wb_ack;
    // Both low lanes must be enabled, else a half instruction would run
    assign exec = req && i_wb_we && i_wb_sel[0] && i_wb_sel[1]
                  && (i_wb_adr == mcu_seq_pkg::ADR_INSTR);
    assign ins  = mcu_seq_pkg::instr_t'(i_wb_dat[15:0]);

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_wb_ack <= 1'b0;
        end else begin
            o_wb_ack <= req;
        end
    end

    // ----------------------------------------------------------------
    // Working state
    // ----------------------------------------------------------------
    logic [3:0]   acc_ff;
    logic [3:0]   y_ff;
    logic [2:0]   x_ff;
    logic         stat_ff;
    logic         slatch_ff;
    logic [5:0]   pc_ff;
    logic [3:0]   page_ff;
    logic [3:0]   pbuf_ff;
    logic [5:0]   ret_pc_ff;
    logic [3:0]   ret_page_ff;
    logic         chap_ff;
    logic         cbuf_ff;
    logic         csub_ff;
    logic [3:0]   ram_ff [mcu_seq_pkg::RAM_WORDS];
    logic [6:0]   ram_idx;
    logic [3:0]   mem;
    logic [3:0]   nxt_acc;
    logic [3:0]   nxt_y;
    logic [2:0]   nxt_x;
    logic         nxt_stat;
    logic         nxt_slatch;
    logic         ram_we;
    logic [3:0]   ram_wd;
    logic [4:0]   s;
    logic [3:0]   bmask;
    logic         jump_ok;

    // Data memory: file pointer is the upper index, word pointer the lower
    assign ram_idx = {x_ff, y_ff};
    assign mem     = ram_ff[ram_idx];
    assign bmask   = 4'h1 << ins.arg[1:0];
    assign jump_ok = exec && stat_ff;

    function automatic logic [4:0] add5(input logic [3:0] a,
                                        input logic [3:0] b,
                                        input logic       ci);
        add5 = {1'b0, a} + {1'b0, b} + {4'h0, ci};
    endfunction

    // ----------------------------------------------------------------
    // Execute unit
    // ----------------------------------------------------------------
    always_comb begin
        nxt_acc    = acc_ff;
        nxt_y      = y_ff;
        nxt_x      = x_ff;
        nxt_stat   = 1'b1;
        nxt_slatch = slatch_ff;
        ram_we     = 1'b0;
        ram_wd     = acc_ff;
        s          = 5'h00;
        unique case (ins.op)
            mcu_seq_pkg::OP_ACC_TO_Y:  nxt_y = acc_ff;
            mcu_seq_pkg::OP_Y_TO_ACC:  nxt_acc = y_ff;
            mcu_seq_pkg::OP_ZERO_ACC:  nxt_acc = mcu_seq_pkg::ZERO4;
            mcu_seq_pkg::OP_STORE:     ram_we = 1'b1;
            mcu_seq_pkg::OP_STORE_ZERO: begin
                ram_we  = 1'b1;
                nxt_acc = mcu_seq_pkg::ZERO4;
            end
            mcu_seq_pkg::OP_LOAD_Y:    nxt_y = mem;
            mcu_seq_pkg::OP_LOAD_ACC:  nxt_acc = mem;
            mcu_seq_pkg::OP_SWAP: begin
                ram_we  = 1'b1;
                nxt_acc = mem;
            end
            mcu_seq_pkg::OP_STORE_INC_Y, mcu_seq_pkg::OP_INC_Y: begin
                ram_we   = (ins.op == mcu_seq_pkg::OP_STORE_INC_Y);
                s        = add5(y_ff, mcu_seq_pkg::ZERO4, 1'b1);
                nxt_y    = s[3:0];
                nxt_stat = s[4];
            end
            mcu_seq_pkg::OP_STORE_DEC_Y, mcu_seq_pkg::OP_DEC_Y: begin
                ram_we   = (ins.op == mcu_seq_pkg::OP_STORE_DEC_Y);
                s        = add5(y_ff, mcu_seq_pkg::ONES4, 1'b0);
                nxt_y    = s[3:0];
                nxt_stat = s[4];
            end
            mcu_seq_pkg::OP_ADD_RAM, mcu_seq_pkg::OP_INC_RAM,
            mcu_seq_pkg::OP_INC_ACC, mcu_seq_pkg::OP_ADD_CONST: begin
                unique case (ins.op)
                    mcu_seq_pkg::OP_ADD_RAM:
                        s = add5(acc_ff, mem, 1'b0);
                    mcu_seq_pkg::OP_INC_RAM:
                        s = add5(mem, mcu_seq_pkg::ZERO4, 1'b1);
                    mcu_seq_pkg::OP_INC_ACC:
                        s = add5(acc_ff, mcu_seq_pkg::ZERO4, 1'b1);
                    default:
                        s = add5(acc_ff, ins.arg[3:0], 1'b0);
                endcase
                nxt_acc  = s[3:0];
                nxt_stat = s[4];
            end
            mcu_seq_pkg::OP_SUB_RAM, mcu_seq_pkg::OP_DEC_RAM,
            mcu_seq_pkg::OP_DEC_ACC: begin
                // Carry of an add with the inverted operand is no-borrow
                unique case (ins.op)
                    mcu_seq_pkg::OP_SUB_RAM:
                        s = add5(mem, ~acc_ff, 1'b1);
                    mcu_seq_pkg::OP_DEC_RAM:
                        s = add5(mem, mcu_seq_pkg::ONES4, 1'b0);
                    default:
                        s = add5(acc_ff, mcu_seq_pkg::ONES4, 1'b0);
                endcase
                nxt_acc  = s[3:0];
                nxt_stat = s[4];
            end
            mcu_seq_pkg::OP_NEG_ZT: begin
                s        = add5(~acc_ff, mcu_seq_pkg::ZERO4, 1'b1);
                nxt_acc  = s[3:0];
                nxt_stat = (s[3:0] == mcu_seq_pkg::ZERO4);
            end
            mcu_seq_pkg::OP_ACC_LE:     nxt_stat = (acc_ff <= mem);
            mcu_seq_pkg::OP_RAM_NE_ACC: nxt_stat = (mem != acc_ff);
            mcu_seq_pkg::OP_RAM_NZ:
                nxt_stat = (mem != mcu_seq_pkg::ZERO4);
            mcu_seq_pkg::OP_Y_NE_ACC: begin
                nxt_stat   = (y_ff != acc_ff);
                nxt_slatch = (y_ff != acc_ff);
            end
            mcu_seq_pkg::OP_Y_NE_K:     nxt_stat = (y_ff != ins.arg[3:0]);
            mcu_seq_pkg::OP_SET_BIT: begin
                ram_we = 1'b1;
                ram_wd = mem | bmask;
            end
            mcu_seq_pkg::OP_CLR_BIT: begin
                ram_we = 1'b1;
                ram_wd = mem & ~bmask;
            end
            mcu_seq_pkg::OP_TEST_BIT:
                nxt_stat = ((mem & bmask) != mcu_seq_pkg::ZERO4);
            mcu_seq_pkg::OP_K_TO_Y:     nxt_y = ins.arg[3:0];
            mcu_seq_pkg::OP_K_STORE_INC: begin
                ram_we = 1'b1;
                ram_wd = ins.arg[3:0];
                s      = add5(y_ff, mcu_seq_pkg::ZERO4, 1'b1);
                nxt_y  = s[3:0];
            end
            mcu_seq_pkg::OP_KEYS_NZ:
                nxt_stat = (i_keys != mcu_seq_pkg::ZERO4);
            mcu_seq_pkg::OP_KEYS_TO_ACC: nxt_acc = i_keys;
            mcu_seq_pkg::OP_LOAD_X:     nxt_x = ins.arg[2:0];
            mcu_seq_pkg::OP_FLIP_X:     nxt_x = x_ff ^ mcu_seq_pkg::X_MSB;
            default: ;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            acc_ff    <= mcu_seq_pkg::ZERO4;
            y_ff      <= mcu_seq_pkg::ZERO4;
            x_ff      <= '0;
            stat_ff   <= mcu_seq_pkg::STAT_RST;
            slatch_ff <= 1'b0;
        end else if (exec) begin
            acc_ff    <= nxt_acc;
            y_ff      <= nxt_y;
            x_ff      <= nxt_x;
            stat_ff   <= nxt_stat;
            slatch_ff <= nxt_slatch;
        end
    end

    // No reset on the memory array; contents are undefined at power-up
    always_ff @(posedge i_sys_clk) begin
        if (exec && ram_we) begin
            ram_ff[ram_idx] <= ram_wd;
        end
    end

    // ----------------------------------------------------------------
    // Program sequencer and chapter logic
    // ----------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            pc_ff       <= mcu_seq_pkg::PC_RST;
            page_ff     <= mcu_seq_pkg::PAGE_RST;
            pbuf_ff     <= mcu_seq_pkg::PAGE_RST;
            ret_pc_ff   <= mcu_seq_pkg::PC_RST;
            ret_page_ff <= mcu_seq_pkg::PAGE_RST;
        end else if (exec) begin
            // 64 words per page, 16 pages per chapter
            pc_ff <= pc_ff + 6'h01;
            if (ins.op == mcu_seq_pkg::OP_LOAD_PBUF) begin
                pbuf_ff <= ins.arg[3:0];
            end
            if (jump_ok && (ins.op == mcu_seq_pkg::OP_JUMP
                            || ins.op == mcu_seq_pkg::OP_CALL)) begin
                pc_ff   <= ins.arg[5:0];
                page_ff <= pbuf_ff;
            end
            if (jump_ok && ins.op == mcu_seq_pkg::OP_CALL) begin
                ret_pc_ff   <= pc_ff + 6'h01;
                ret_page_ff <= page_ff;
            end
            if (ins.op == mcu_seq_pkg::OP_RETURN) begin
                pc_ff   <= ret_pc_ff;
                page_ff <= ret_page_ff;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            chap_ff <= 1'b0;
            cbuf_ff <= 1'b0;
            csub_ff <= 1'b0;
        end else if (exec) begin
            if (ins.op == mcu_seq_pkg::OP_FLIP_CBUF) begin
                cbuf_ff <= ~cbuf_ff;
            end
            if (jump_ok && (ins.op == mcu_seq_pkg::OP_JUMP
                            || ins.op == mcu_seq_pkg::OP_CALL)) begin
                chap_ff <= cbuf_ff;
            end
            if (jump_ok && ins.op == mcu_seq_pkg::OP_CALL) begin
                csub_ff <= chap_ff;
            end
            if (ins.op == mcu_seq_pkg::OP_RETURN) begin
                chap_ff <= csub_ff;
            end
        end
    end

    // ----------------------------------------------------------------
    // Output latches
    // ----------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_strobe <= '0;
            o_par    <= '0;
        end else if (exec) begin
            // Y beyond the latch count is ignored; X is left to software
            if (32'(y_ff) < N_STROBE) begin
                if (ins.op == mcu_seq_pkg::OP_RAISE_STB) begin
                    o_strobe[y_ff] <= 1'b1;
                end
                if (ins.op == mcu_seq_pkg::OP_DROP_STB) begin
                    o_strobe[y_ff] <= 1'b0;
                end
            end
            if (ins.op == mcu_seq_pkg::OP_DRIVE_PAR) begin
                o_par <= PAR_W'({slatch_ff, acc_ff});
            end
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    always_comb begin
        nxt_rdat = 32'h0000_0000;
        unique case (i_wb_adr)
            mcu_seq_pkg::ADR_STATE:
                nxt_rdat[15:0] = {csub_ff, cbuf_ff, chap_ff, slatch_ff,
                                  stat_ff, x_ff, y_ff, acc_ff};
            mcu_seq_pkg::ADR_SEQ:
                nxt_rdat[23:0] = {ret_page_ff, ret_pc_ff, pbuf_ff,
                                  page_ff, pc_ff};
            mcu_seq_pkg::ADR_IO:
                nxt_rdat[27:0] = {i_keys, 8'(o_par), 16'(o_strobe)};
            default: nxt_rdat = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_wb_dat <= 32'h0000_0000;
        end else if (req && !i_wb_we) begin
            o_wb_dat <= nxt_rdat;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);

    a_cbuf_flip_only: assert property (
        exec && ins.op == mcu_seq_pkg::OP_FLIP_CBUF |=>
        cbuf_ff != $past(cbuf_ff) && chap_ff == $past(chap_ff)
        && csub_ff == $past(csub_ff)) else $error("buffer flip wrong");
    a_jump_chapter: assert property (
        exec && stat_ff && ins.op == mcu_seq_pkg::OP_JUMP |=>
        chap_ff == $past(cbuf_ff) && page_ff == $past(pbuf_ff))
        else $error("taken jump lost chapter");
    a_jump_untaken: assert property (
        exec && !stat_ff && ins.op == mcu_seq_pkg::OP_JUMP |=>
        chap_ff == $past(chap_ff) && pc_ff == $past(pc_ff) + 6'h01)
        else $error("untaken jump moved");
    a_call_saves: assert property (
        exec && stat_ff && ins.op == mcu_seq_pkg::OP_CALL |=>
        csub_ff == $past(chap_ff)) else $error("call return bit");
    a_return_restore: assert property (
        exec && ins.op == mcu_seq_pkg::OP_RETURN |=>
        chap_ff == $past(csub_ff) && pc_ff == $past(ret_pc_ff))
        else $error("return restore wrong");
    a_status_revert: assert property (
        exec && ins.op == mcu_seq_pkg::OP_STORE |=> stat_ff)
        else $error("status not one");
    a_sub_result: assert property (
        exec && ins.op == mcu_seq_pkg::OP_SUB_RAM |=>
        acc_ff == 4'($past(mem) - $past(acc_ff))
        && stat_ff == ($past(mem) >= $past(acc_ff)))
        else $error("subtract wrong");
    a_incacc_carry: assert property (
        exec && ins.op == mcu_seq_pkg::OP_INC_ACC |=>
        stat_ff == ($past(acc_ff) == mcu_seq_pkg::ONES4))
        else $error("increment carry wrong");
    a_neg_zero: assert property (
        exec && ins.op == mcu_seq_pkg::OP_NEG_ZT |=>
        acc_ff == 4'(-$past(acc_ff)) && stat_ff == (acc_ff == 4'h0))
        else $error("negate wrong");
    a_flip_x_msb: assert property (
        exec && ins.op == mcu_seq_pkg::OP_FLIP_X |=>
        x_ff == ($past(x_ff) ^ mcu_seq_pkg::X_MSB))
        else $error("file flip wrong");
    a_ack_single: assert property (
        o_wb_ack |=> !o_wb_ack) else $error("ack held");

    c_taken_call: cover property (
        exec && stat_ff && ins.op == mcu_seq_pkg::OP_CALL);
    c_zero_then_jump: cover property (
        exec && !stat_ff && ins.op == mcu_seq_pkg::OP_JUMP);
    c_strobe_raise: cover property (
        exec && ins.op == mcu_seq_pkg::OP_RAISE_STB);
endmodule

/* File: logic/mcu_seq_pkg.sv */
package mcu_seq_pkg;
    // ----------------------------------------------------------------
    // Geometry
    // ----------------------------------------------------------------
    localparam int DATA_W     = 4;
    localparam int PC_W       = 6;
    localparam int PAGE_W     = 4;
    localparam int X_W        = 3;
    localparam int PAGE_WORDS = 64;
    localparam int PAGES      = 16;
    localparam int CHAPTERS   = 2;
    localparam int RAM_WORDS  = 128;
    localparam int N_STROBE   = 16;
    localparam int PAR_W      = 8;

    // ----------------------------------------------------------------
    // Register map, byte addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] ADR_INSTR = 8'h00;
    localparam logic [7:0] ADR_STATE = 8'h04;
    localparam logic [7:0] ADR_SEQ   = 8'h08;
    localparam logic [7:0] ADR_IO    = 8'h0c;

    // ----------------------------------------------------------------
    // Reset values and small constants
    // ----------------------------------------------------------------
    localparam logic [PC_W-1:0]   PC_RST   = 6'h00;
    localparam logic [PAGE_W-1:0] PAGE_RST = 4'hf;
    localparam logic              STAT_RST = 1'b1;
    localparam logic [DATA_W-1:0] ZERO4    = 4'h0;
    localparam logic [DATA_W-1:0] ONES4    = 4'hf;
    localparam logic [X_W-1:0]    X_MSB    = 3'h4;

    typedef enum logic [7:0] {
        OP_ACC_TO_Y, OP_Y_TO_ACC, OP_ZERO_ACC, OP_STORE, OP_STORE_INC_Y,
        OP_STORE_DEC_Y, OP_STORE_ZERO, OP_LOAD_Y, OP_LOAD_ACC, OP_SWAP,
        OP_ADD_RAM, OP_SUB_RAM, OP_INC_RAM, OP_DEC_RAM, OP_INC_ACC,
        OP_DEC_ACC, OP_ADD_CONST, OP_INC_Y, OP_DEC_Y, OP_NEG_ZT,
        OP_ACC_LE, OP_RAM_NE_ACC, OP_RAM_NZ, OP_Y_NE_ACC, OP_Y_NE_K,
        OP_SET_BIT, OP_CLR_BIT, OP_TEST_BIT, OP_K_TO_Y, OP_K_STORE_INC,
        OP_KEYS_NZ, OP_KEYS_TO_ACC, OP_RAISE_STB, OP_DROP_STB, OP_DRIVE_PAR,
        OP_LOAD_X, OP_FLIP_X, OP_JUMP, OP_CALL, OP_RETURN, OP_LOAD_PBUF,
        OP_FLIP_CBUF
    } op_t;

    typedef struct packed {
        op_t        op;
        logic [7:0] arg;
    } instr_t;
endpackage

/* File: testbench/key_matrix.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Key matrix on the strobe lines
// ----------------------------------------------------------------
module key_matrix (
    input  wire logic [15:0] i_strobe, // Strobe latches
    output logic      [3:0]  o_keys    // Sense lines
);
    // Row r closes pattern r xor 5; open lines are pulled to 0
    always_comb begin
        o_keys = 4'h0;
        for (int r = 0; r < 16; r++) begin
            if (i_strobe[r]) begin
                o_keys = o_keys | (r[3:0] ^ 4'h5);
            end
        end
    end
endmodule

/* File: testbench/test_four_bit_mcu_chapter_sequencer.sv */
`timescale 1ns/1ps
module test_four_bit_mcu_chapter_sequencer;
    // ------------------------------------------------------------
    // Bench plumbing
    // ------------------------------------------------------------
    logic        sys_clk = 1'b0;
    logic        nrst = 1'b0;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic        ack;
    logic [3:0]  keys;
    logic [15:0] strobe;
    logic [7:0]  par;
    int          err_total = 0, cmp_count = 0;
    always #2.5 sys_clk = ~sys_clk;
    mcu_seq i_dut (
        .i_sys_clk (sys_clk), .i_nrst (nrst), .i_wb_cyc (cyc),
        .i_wb_stb (stb), .i_wb_we (we), .i_wb_adr (adr),
        .i_wb_sel (sel), .i_wb_dat (wdat), .o_wb_dat (rdat),
        .o_wb_ack (ack), .i_keys (keys), .o_strobe (strobe),
        .o_par (par)
    );
    key_matrix i_pad (.i_strobe (strobe), .o_keys (keys));
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s);
        {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, s, d};
        @(posedge sys_clk);
        while (ack !== 1'b1) begin
            @(posedge sys_clk);
        end
        q = rdat;
        {cyc, stb} <= 2'b00;
        // Idle cycle keeps cyc low between requests
        @(posedge sys_clk);
    endtask
    task automatic ck(input logic [7:0] a, input logic [31:0] m, e);
        wb(1'b0, a, 32'h0, 4'hf);
        cmp_count++;
        if ((q & m) !== e) begin
            err_total++;
            $display("wrong value at %0t: adr %h got %h want %h",
                     $time, a, q & m, e);
        end
    endtask
    task automatic ex(input mcu_seq_pkg::op_t o,
                      input logic [7:0] a = 8'h00);
        wb(1'b1, mcu_seq_pkg::ADR_INSTR, {16'h0, o, a}, 4'hf);
    endtask
    task automatic xv(input mcu_seq_pkg::op_t o, input logic [4:0] e,
                      input logic [7:0] a = 8'h00);
        ex(o, a);
        ck(mcu_seq_pkg::ADR_STATE, 32'h80f, {20'h0, e[4], 7'h0, e[3:0]});
    endtask
    task automatic sa(input logic [3:0] a);
        ex(mcu_seq_pkg::OP_ZERO_ACC);
        ex(mcu_seq_pkg::OP_ADD_CONST, {4'h0, a});
    endtask
    task automatic final_report;
        $display("counts: %0d compares, %0d mismatches",
                 cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Whole run needs about 600 cycles; the 20000-cycle limit is a wide margin
    initial begin
        #100000;
        err_total++;
        $display("wrong value at %0t: watchdog expired", $time);
        final_report();
    end
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        ck(mcu_seq_pkg::ADR_STATE, 32'hefff, 32'h0800);
        ck(mcu_seq_pkg::ADR_SEQ, 32'h3fff, 32'h3fc0);
        ck(8'h40, 32'hffffffff, 32'h0);
        for (int k = 2; k < 15; k++) begin
            sa(4'(k));
            xv(mcu_seq_pkg::OP_ADD_CONST, {k > 7, 4'(2 * k)}, 8'(k));
        end
        $display("test arithmetic done");
        ex(mcu_seq_pkg::OP_FLIP_CBUF);
        ck(mcu_seq_pkg::ADR_STATE, 32'he000, 32'h4000);
        sa(4'he);
        xv(mcu_seq_pkg::OP_INC_ACC, 5'h0f);
        xv(mcu_seq_pkg::OP_INC_ACC, 5'h10);
        xv(mcu_seq_pkg::OP_DEC_ACC, 5'h0f);
        ex(mcu_seq_pkg::OP_JUMP, 8'h2a);
        ck(mcu_seq_pkg::ADR_STATE, 32'he800, 32'h4800);
        ex(mcu_seq_pkg::OP_JUMP, 8'h2a);
        ck(mcu_seq_pkg::ADR_STATE, 32'he000, 32'h6000);
        ck(mcu_seq_pkg::ADR_SEQ, 32'h3f, 32'h2a);
        ex(mcu_seq_pkg::OP_FLIP_CBUF);
        ex(mcu_seq_pkg::OP_LOAD_PBUF, 8'h05);
        ck(mcu_seq_pkg::ADR_SEQ, 32'h3c00, 32'h1400);
        ex(mcu_seq_pkg::OP_CALL, 8'h11);
        ck(mcu_seq_pkg::ADR_STATE, 32'he000, 32'h8000);
        ex(mcu_seq_pkg::OP_FLIP_CBUF);
        ck(mcu_seq_pkg::ADR_STATE, 32'he000, 32'hc000);
        ex(mcu_seq_pkg::OP_RETURN);
        ck(mcu_seq_pkg::ADR_STATE, 32'h2000, 32'h2000);
        $display("test chapters done");
        ex(mcu_seq_pkg::OP_LOAD_X, 8'h05);
        ex(mcu_seq_pkg::OP_FLIP_X);
        ck(mcu_seq_pkg::ADR_STATE, 32'h700, 32'h100);
        ex(mcu_seq_pkg::OP_K_TO_Y, 8'h03);
        sa(4'h9);
        ex(mcu_seq_pkg::OP_STORE);
        ex(mcu_seq_pkg::OP_LOAD_X, 8'h05);
        sa(4'h2);
        ex(mcu_seq_pkg::OP_STORE);
        ex(mcu_seq_pkg::OP_LOAD_X, 8'h01);
        xv(mcu_seq_pkg::OP_LOAD_ACC, 5'h19);
        sa(4'h4);
        xv(mcu_seq_pkg::OP_SUB_RAM, 5'h15);
        sa(4'hb);
        xv(mcu_seq_pkg::OP_SUB_RAM, 5'h0e);
        xv(mcu_seq_pkg::OP_ACC_LE, 5'h0e);
        sa(4'h9);
        xv(mcu_seq_pkg::OP_ACC_LE, 5'h19);
        xv(mcu_seq_pkg::OP_RAM_NE_ACC, 5'h09);
        ex(mcu_seq_pkg::OP_SET_BIT, 8'h01);
        xv(mcu_seq_pkg::OP_LOAD_ACC, 5'h1b);
        ex(mcu_seq_pkg::OP_CLR_BIT, 8'h00);
        xv(mcu_seq_pkg::OP_TEST_BIT, 5'h0b, 8'h00);
        xv(mcu_seq_pkg::OP_TEST_BIT, 5'h1b, 8'h03);
        xv(mcu_seq_pkg::OP_SWAP, 5'h1a);
        xv(mcu_seq_pkg::OP_LOAD_ACC, 5'h1b);
        ex(mcu_seq_pkg::OP_STORE_INC_Y);
        ck(mcu_seq_pkg::ADR_STATE, 32'h8f0, 32'h040);
        ex(mcu_seq_pkg::OP_K_TO_Y, 8'h00);
        ex(mcu_seq_pkg::OP_DEC_Y);
        ck(mcu_seq_pkg::ADR_STATE, 32'h8f0, 32'h0f0);
        sa(4'h3);
        xv(mcu_seq_pkg::OP_NEG_ZT, 5'h0d);
        ex(mcu_seq_pkg::OP_ZERO_ACC);
        xv(mcu_seq_pkg::OP_NEG_ZT, 5'h10);
        ex(mcu_seq_pkg::OP_K_TO_Y, 8'h03);
        xv(mcu_seq_pkg::OP_ADD_RAM, 5'h0b);
        xv(mcu_seq_pkg::OP_ADD_RAM, 5'h16);
        xv(mcu_seq_pkg::OP_INC_RAM, 5'h0c);
        xv(mcu_seq_pkg::OP_DEC_RAM, 5'h1a);
        xv(mcu_seq_pkg::OP_STORE_ZERO, 5'h10);
        ex(mcu_seq_pkg::OP_LOAD_Y);
        ck(mcu_seq_pkg::ADR_STATE, 32'hff, 32'ha0);
        xv(mcu_seq_pkg::OP_Y_TO_ACC, 5'h1a);
        xv(mcu_seq_pkg::OP_Y_NE_K, 5'h0a, 8'h0a);
        ex(mcu_seq_pkg::OP_K_STORE_INC, 8'h05);
        ck(mcu_seq_pkg::ADR_STATE, 32'hf0, 32'hb0);
        ex(mcu_seq_pkg::OP_STORE_DEC_Y);
        ck(mcu_seq_pkg::ADR_STATE, 32'h8f0, 32'h8a0);
        xv(mcu_seq_pkg::OP_RAM_NZ, 5'h1a);
        xv(mcu_seq_pkg::OP_LOAD_ACC, 5'h15);
        ex(mcu_seq_pkg::OP_INC_Y);
        ck(mcu_seq_pkg::ADR_STATE, 32'h8f0, 32'h0b0);
        xv(mcu_seq_pkg::OP_LOAD_ACC, 5'h1a);
        ex(mcu_seq_pkg::OP_ZERO_ACC);
        ex(mcu_seq_pkg::OP_ACC_TO_Y);
        ck(mcu_seq_pkg::ADR_STATE, 32'hff, 32'h00);
        ex(mcu_seq_pkg::OP_Y_NE_K, 8'h00);
        ex(mcu_seq_pkg::OP_CALL, 8'h33);
        ck(mcu_seq_pkg::ADR_STATE, 32'he800, 32'he800);
        $display("test memory done");
        ex(mcu_seq_pkg::OP_LOAD_X, 8'h00);
        ex(mcu_seq_pkg::OP_K_TO_Y, 8'h02);
        ex(mcu_seq_pkg::OP_RAISE_STB);
        ex(mcu_seq_pkg::OP_K_TO_Y, 8'h0f);
        ex(mcu_seq_pkg::OP_RAISE_STB);
        ck(mcu_seq_pkg::ADR_IO, 32'hf00ffff, 32'hf008004);
        xv(mcu_seq_pkg::OP_KEYS_TO_ACC, 5'h1f);
        ex(mcu_seq_pkg::OP_K_TO_Y, 8'h02);
        ex(mcu_seq_pkg::OP_DROP_STB);
        ck(mcu_seq_pkg::ADR_IO, 32'hffff, 32'h8000);
        xv(mcu_seq_pkg::OP_KEYS_NZ, 5'h1f);
        xv(mcu_seq_pkg::OP_KEYS_TO_ACC, 5'h1a);
        ex(mcu_seq_pkg::OP_K_TO_Y, 8'h0f);
        ex(mcu_seq_pkg::OP_DROP_STB);
        xv(mcu_seq_pkg::OP_KEYS_NZ, 5'h0a);
        xv(mcu_seq_pkg::OP_Y_NE_ACC, 5'h1a);
        ex(mcu_seq_pkg::OP_DRIVE_PAR);
        ck(mcu_seq_pkg::ADR_IO, 32'hff0000, 32'h1a0000);
        wb(1'b1, mcu_seq_pkg::ADR_INSTR, 32'h0000_0200, 4'hc);
        ck(mcu_seq_pkg::ADR_STATE, 32'hf, 32'ha);
        $display("test io done");
        final_report();
    end
endmodule
